/* src/msd_decoder.sv */
// memory space decoder: target choice, cache attributes, apb registers
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module msd_decoder (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // processor or local-bus memory cycle
   input wire logic cyc_valid,
   input wire logic cyc_write,
   input wire logic [31:0] cyc_addr,
   input wire logic dram_bank_hit,
   input wire logic local_dev_claim_n,
   // cycle results
   output logic decode_valid,
   output logic [3:0] target,
   output logic boot_rom_select_n,
   output logic isa_mem_read_n,
   output logic isa_mem_write_n,
   output logic peripheral_data_bus_steer,
   output logic [23:0] isa_addr,
   output logic [27:0] dram_addr,
   // cache attributes
   output logic l1_cacheable,
   output logic l2_cacheable,
   output logic cpu_writeback_select,
   // window chip selects for multifunction pins
   output logic [1:0] window_chip_select
);

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [7:0] win_base_lo [2];
   logic [7:0] win_base_hi [2];
   logic [7:0] win_ctrl [2];
   logic [7:0] win_cache [2];
   logic [7:0] shadow_rd;
   logic [7:0] shadow_wr;
   logic [7:0] video_flash;
   logic [7:0] cache_cfg;
   logic [7:0] status;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire logic [7:0] idx = paddr[9:2];
   wire logic in_range = paddr[11:10] == 2'h0;
   wire logic setup = psel && !penable;
   wire logic acc = psel && penable;
   wire logic wr_en = acc && pwrite && pstrb[0];
   wire logic hit_w0 = in_range && idx[7:2] == msd_pkg::IDX_WIN0_BASE_LO[7:2];
   wire logic hit_w1 = in_range && idx[7:2] == msd_pkg::IDX_WIN1_BASE_LO[7:2];
   wire logic hit_win = hit_w0 || hit_w1;
   wire logic win_sel = hit_w1;
   wire logic hit_srd = in_range && idx == msd_pkg::IDX_SHADOW_RD;
   wire logic hit_swr = in_range && idx == msd_pkg::IDX_SHADOW_WR;
   wire logic hit_vf = in_range && idx == msd_pkg::IDX_VIDEO_FLASH;
   wire logic hit_cfg = in_range && idx == msd_pkg::IDX_CACHE_CFG;
   wire logic hit_st = in_range && idx == msd_pkg::IDX_STATUS;
   wire logic mapped = hit_win || hit_srd || hit_swr || hit_vf || hit_cfg
                       || hit_st;

   // zero wait states: read data is caught in the setup cycle
   assign pready = acc;
   assign pslverr = acc && !mapped;

   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (hit_win) begin
         case (idx[1:0])
            2'h0: rd_byte = win_base_lo[win_sel];
            2'h1: rd_byte = win_base_hi[win_sel];
            2'h2: rd_byte = win_ctrl[win_sel] & 8'h6F;
            default: rd_byte = win_cache[win_sel] & 8'h03;
         endcase
      end else if (hit_srd) begin
         rd_byte = shadow_rd & 8'h7F;
      end else if (hit_swr) begin
         rd_byte = shadow_wr & 8'h7F;
      end else if (hit_vf) begin
         rd_byte = video_flash & 8'hF3;
      end else if (hit_cfg) begin
         rd_byte = cache_cfg & 8'h03;
      end else if (hit_st) begin
         rd_byte = status;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2; i++) begin
            win_base_lo[i] <= msd_pkg::REG_RESET;
            win_base_hi[i] <= msd_pkg::REG_RESET;
            win_ctrl[i] <= msd_pkg::REG_RESET;
            win_cache[i] <= msd_pkg::REG_RESET;
         end
         shadow_rd <= msd_pkg::REG_RESET;
         shadow_wr <= msd_pkg::REG_RESET;
         video_flash <= msd_pkg::REG_RESET;
         cache_cfg <= msd_pkg::REG_RESET;
      end else if (wr_en) begin
         if (hit_win) begin
            case (idx[1:0])
               2'h0: win_base_lo[win_sel] <= pwdata[7:0];
               2'h1: win_base_hi[win_sel] <= pwdata[7:0];
               2'h2: win_ctrl[win_sel] <= pwdata[7:0];
               default: win_cache[win_sel] <= pwdata[7:0];
            endcase
         end
         if (hit_srd) shadow_rd <= pwdata[7:0];
         if (hit_swr) shadow_wr <= pwdata[7:0];
         if (hit_vf) video_flash <= pwdata[7:0];
         if (hit_cfg) cache_cfg <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // local device claim pin
   // ----------------------------------------------------------------
   logic ldev_n_sync;
   msd_sync3 #(.RESET_VAL(1'b1)) u_ldev_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(local_dev_claim_n),
      .q(ldev_n_sync)
   );

   // ----------------------------------------------------------------
   // programmable windows
   // ----------------------------------------------------------------
   msd_window_if win_if0 ();
   msd_window_if win_if1 ();

   assign win_if0.base = {win_base_hi[0], win_base_lo[0]};
   assign win_if0.size_code = win_ctrl[0][3:0];
   assign win_if0.addr = cyc_addr;
   assign win_if1.base = {win_base_hi[1], win_base_lo[1]};
   assign win_if1.size_code = win_ctrl[1][3:0];
   assign win_if1.addr = cyc_addr;

   msd_window_match u_win0 (.win(win_if0));
   msd_window_match u_win1 (.win(win_if1));

   wire logic [1:0] win_hit = {win_if1.hit, win_if0.hit};
   wire logic [1:0] win_hole;
   wire logic [1:0] win_force;
   wire logic [1:0] win_attr_on;

   // a window with no attributes set changes only its chip select and status bit
   for (genvar w = 0; w < 2; w++) begin : g_win
      assign win_hole[w] = win_hit[w] && win_ctrl[w][msd_pkg::CTRL_HOLE_BIT];
      assign win_force[w] = win_hit[w]
                            && win_ctrl[w][msd_pkg::CTRL_FORCE_BIT];
      assign win_attr_on[w] = win_hit[w] && win_cache[w][1:0] != 2'h0;
   end

   // overlapping windows: union of hole and force
   wire logic hole_any = |win_hole;
   wire logic force_any = |win_force;

   // window 0 cache code wins whenever it names one
   wire msd_pkg::msd_cache_attr_t attr =
      win_attr_on[0] ? msd_pkg::msd_cache_attr_t'(win_cache[0][1:0]) :
      win_attr_on[1] ? msd_pkg::msd_cache_attr_t'(win_cache[1][1:0]) :
      msd_pkg::CA_DEFAULT;

   // ----------------------------------------------------------------
   // fixed and shadow decodes, bits 30:28 ignored
   // ----------------------------------------------------------------
   wire logic a31 = cyc_addr[31];
   wire logic [7:0] a_mb = cyc_addr[27:20];
   wire logic [3:0] seg = cyc_addr[19:16];
   wire logic top_rom = a31 && a_mb == msd_pkg::TOP_ROM_BITS;
   wire logic low_mb = !a31 && a_mb == 8'h00;
   wire logic in_video = low_mb && (seg == 4'hA || seg == 4'hB);
   wire logic in_bios = low_mb && seg >= 4'hC;
   wire logic in_ef = low_mb && seg >= 4'hE;

   // normal shadow bit: C in four 16K pieces, then D, E, F
   function automatic logic shadow_bit(input logic [7:0] bits,
                                       input logic [3:0] s,
                                       input logic [1:0] q16k);
      case (s)
         4'hC: shadow_bit = bits[q16k];
         4'hD: shadow_bit = bits[4];
         4'hE: shadow_bit = bits[5];
         4'hF: shadow_bit = bits[6];
         default: shadow_bit = 1'b0;
      endcase
   endfunction

   wire logic [1:0] q16k = cyc_addr[15:14];
   wire logic [1:0] flash_sel = {cyc_addr[16], cyc_addr[15]};
   wire logic [3:0] flash_bits = video_flash[msd_pkg::VF_FLASH_LSB +: 4];
   wire logic flash_on = in_ef && flash_bits[flash_sel];
   wire logic video_on = (seg == 4'hA)
                         ? video_flash[msd_pkg::VF_VIDEO_A_BIT]
                         : video_flash[msd_pkg::VF_VIDEO_B_BIT];
   wire logic [7:0] rw_bits = cyc_write ? shadow_wr : shadow_rd;
   wire logic bios_on = shadow_bit(rw_bits, seg, q16k) || flash_on;

   // shadow ranges ignore the bank decode entirely
   wire logic dram_base = in_video ? video_on :
                          in_bios ? bios_on :
                          dram_bank_hit;
   // lower half only; aliases onto the lowest 256MB
   wire logic dram_claim = !a31 && dram_base && !hole_any;
   // forcing takes the cycle from isa and rom only, not from dram
   wire logic local_claim = !ldev_n_sync || force_any;

   msd_pkg::msd_target_t next_target;
   always_comb begin
      if (dram_claim) begin
         next_target = msd_pkg::TGT_DRAM;
      end else if (local_claim) begin
         next_target = msd_pkg::TGT_LOCAL;
      end else if (top_rom) begin
         next_target = msd_pkg::TGT_ROM;
      end else begin
         next_target = msd_pkg::TGT_ISA;
      end
   end

   wire logic to_dram = next_target == msd_pkg::TGT_DRAM;
   wire logic isa_side = next_target == msd_pkg::TGT_ISA
                         || next_target == msd_pkg::TGT_ROM;

   // ----------------------------------------------------------------
   // cache attributes
   // ----------------------------------------------------------------
   wire logic l1_wb_default = cache_cfg[msd_pkg::CFG_L1_WB_BIT];
   wire logic l2_enable = cache_cfg[msd_pkg::CFG_L2_EN_BIT];
   wire logic forced_l1 = attr == msd_pkg::CA_WT_L1
                          || attr == msd_pkg::CA_WB_L1;
   wire logic next_l1 = forced_l1
                        || (to_dram && attr != msd_pkg::CA_NONCACHE);
   // second level holds local dram only; the l1 codes leave it alone
   wire logic next_l2 = to_dram && l2_enable
                        && attr != msd_pkg::CA_NONCACHE;
   logic next_wb;
   always_comb begin
      case (attr)
         msd_pkg::CA_WT_L1: next_wb = 1'b0;
         msd_pkg::CA_WB_L1: next_wb = 1'b1;
         msd_pkg::CA_NONCACHE: next_wb = 1'b0;
         default: next_wb = l1_wb_default && to_dram;
      endcase
   end

   // ----------------------------------------------------------------
   // registered cycle results
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decode_valid <= 1'b0;
         target <= msd_pkg::TGT_ISA;
         boot_rom_select_n <= 1'b1;
         isa_mem_read_n <= 1'b1;
         isa_mem_write_n <= 1'b1;
         peripheral_data_bus_steer <= 1'b0;
         isa_addr <= 24'h00_0000;
         dram_addr <= 28'h000_0000;
         l1_cacheable <= 1'b0;
         l2_cacheable <= 1'b0;
         cpu_writeback_select <= 1'b0;
         window_chip_select <= 2'h0;
      end else begin
         decode_valid <= cyc_valid;
         if (cyc_valid) begin
            target <= next_target;
            // rom select holds even when a local slave takes the cycle
            boot_rom_select_n <= !top_rom;
            isa_mem_read_n <= !(isa_side && !cyc_write);
            isa_mem_write_n <= !(isa_side && cyc_write);
            peripheral_data_bus_steer <= top_rom && !cyc_write
                                         && !local_claim;
            isa_addr <= cyc_addr[23:0];
            dram_addr <= cyc_addr[27:0];
            l1_cacheable <= next_l1;
            l2_cacheable <= next_l2;
            cpu_writeback_select <= next_wb;
            window_chip_select <= win_hit;
         end else begin
            boot_rom_select_n <= 1'b1;
            isa_mem_read_n <= 1'b1;
            isa_mem_write_n <= 1'b1;
            peripheral_data_bus_steer <= 1'b0;
            window_chip_select <= 2'h0;
         end
      end
   end

   // status shows the last decoded cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= msd_pkg::REG_RESET;
      end else if (cyc_valid) begin
         status <= {win_hit, !ldev_n_sync, hole_any, next_target};
      end
   end

endmodule
`default_nettype wire

/* src/msd_pkg.sv */
// shared constants and types of the memory space decoder
package msd_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_WIN0_BASE_LO = 8'h30;
   localparam logic [7:0] IDX_WIN0_BASE_HI = 8'h31;
   localparam logic [7:0] IDX_WIN0_CTRL = 8'h32;
   localparam logic [7:0] IDX_WIN0_CACHE = 8'h33;
   localparam logic [7:0] IDX_WIN1_BASE_LO = 8'h34;
   localparam logic [7:0] IDX_WIN1_BASE_HI = 8'h35;
   localparam logic [7:0] IDX_WIN1_CTRL = 8'h36;
   localparam logic [7:0] IDX_WIN1_CACHE = 8'h37;
   localparam logic [7:0] IDX_SHADOW_RD = 8'h40;
   localparam logic [7:0] IDX_SHADOW_WR = 8'h41;
   localparam logic [7:0] IDX_VIDEO_FLASH = 8'h42;
   localparam logic [7:0] IDX_CACHE_CFG = 8'h43;
   localparam logic [7:0] IDX_STATUS = 8'h44;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_FORCE_BIT = 6;
   localparam int unsigned CTRL_HOLE_BIT = 5;
   localparam int unsigned VF_VIDEO_A_BIT = 0;
   localparam int unsigned VF_VIDEO_B_BIT = 1;
   localparam int unsigned VF_FLASH_LSB = 4;
   localparam int unsigned CFG_L1_WB_BIT = 0;
   localparam int unsigned CFG_L2_EN_BIT = 1;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] SIZE_CODE_MAX = 4'hB;
   localparam logic [7:0] TOP_ROM_BITS = 8'hFF;
   localparam int unsigned LDEV_SYNC_STAGES = 3;

   // cache attribute codes of a window
   typedef enum logic [1:0] {
      CA_DEFAULT = 2'h0,
      CA_NONCACHE = 2'h1,
      CA_WT_L1 = 2'h2,
      CA_WB_L1 = 2'h3
   } msd_cache_attr_t;

   // cycle target, one-hot
   typedef enum logic [3:0] {
      TGT_ISA = 4'h1,
      TGT_DRAM = 4'h2,
      TGT_LOCAL = 4'h4,
      TGT_ROM = 4'h8
   } msd_target_t;

endpackage

/* src/msd_sync3.sv */
// three-stage synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module msd_sync3 #(
   parameter logic RESET_VAL = 1'b1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // level in and out
   input wire logic din,
   output logic q
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= RESET_VAL;
         s2 <= RESET_VAL;
         s3 <= RESET_VAL;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a change counts only once the last two stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= RESET_VAL;
      end else if (s2 == s3) begin
         q <= s3;
      end
   end
endmodule
`default_nettype wire

/* src/msd_window_if.sv */
// window configuration and match result between decoder and matcher
`timescale 1ns/1ps
`default_nettype none
interface msd_window_if;
   logic [15:0] base;
   logic [3:0] size_code;
   logic [31:0] addr;
   logic hit;

   modport cfg (output base, output size_code, output addr, input hit);
   modport matcher (input base, input size_code, input addr, output hit);
endinterface
`default_nettype wire

/* src/msd_window_match.sv */
// address compare of one programmable memory window
`timescale 1ns/1ps
`default_nettype none
module msd_window_match (
   msd_window_if.matcher win
);
   // codes above the largest size decode as the largest size
   function automatic logic [11:0] size_mask(input logic [3:0] code);
      logic [3:0] c;
      c = (code > msd_pkg::SIZE_CODE_MAX) ? msd_pkg::SIZE_CODE_MAX : code;
      size_mask = 12'hFFF << c;
   endfunction

   wire logic [11:0] mask = size_mask(win.size_code);
   wire logic [11:0] diff = win.addr[27:16] ^ win.base[11:0];
   wire logic top_eq = win.addr[31] == win.base[15];

   // bits 30:28 are never looked at
   assign win.hit = top_eq && ((diff & mask) == 12'h000);
endmodule
`default_nettype wire

/* verification/memory_space_decoder_tb.sv */
// self-checking testbench of the memory space decoder
`timescale 1ns/1ps
`default_nettype none
module memory_space_decoder_tb;
   localparam int LIMIT = 4000;
   localparam logic [3:0] TI = msd_pkg::TGT_ISA;
   localparam logic [3:0] TD = msd_pkg::TGT_DRAM;
   localparam logic [3:0] TL = msd_pkg::TGT_LOCAL;
   localparam logic [3:0] TR = msd_pkg::TGT_ROM;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, cyc_valid = 1'b0, cyc_write = 1'b0;
   logic dram_bank_hit = 1'b0, lcl_en = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, cyc_addr = 32'h0, prdata;
   logic [3:0] pstrb = 4'hF, target;
   logic pready, pslverr, local_dev_claim_n, decode_valid, rom_n;
   logic rd_n, wr_n, steer, l1_cacheable, l2_cacheable, wb_sel;
   logic [23:0] isa_addr;
   logic [27:0] dram_addr;
   logic [1:0] win_cs;
   int n_errors = 0, n_compared = 0, cycles = 0;
   always #50 pclk = ~pclk;
   msd_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cyc_valid(cyc_valid), .cyc_write(cyc_write), .cyc_addr(cyc_addr),
      .dram_bank_hit(dram_bank_hit), .local_dev_claim_n(local_dev_claim_n),
      .decode_valid(decode_valid), .target(target),
      .boot_rom_select_n(rom_n), .isa_mem_read_n(rd_n),
      .isa_mem_write_n(wr_n), .peripheral_data_bus_steer(steer),
      .isa_addr(isa_addr), .dram_addr(dram_addr),
      .l1_cacheable(l1_cacheable), .l2_cacheable(l2_cacheable),
      .cpu_writeback_select(wb_sel), .window_chip_select(win_cs));
   msd_local_slave i_slave (.pclk(pclk), .presetn(presetn),
      .claim_en(lcl_en), .cyc_addr(cyc_addr),
      .local_dev_claim_n(local_dev_claim_n));
   task automatic test_done();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] idx,
      input logic [7:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // no wait-state count is assumed; the loop ends on pready, and only the bench timeout ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 8'h00, r, e);
      chk("prdata", exp, r);
   endtask
   task automatic cyc(input logic [31:0] a, input logic w, input logic h);
      @(posedge pclk);
      cyc_valid <= 1'b1;
      cyc_addr <= a;
      cyc_write <= w;
      dram_bank_hit <= h;
      @(posedge pclk);
      cyc_valid <= 1'b0;
      #1;
   endtask
   // strobe code is {rom select, isa read, isa write, steer}
   task automatic dec(input logic [31:0] a, input logic w, input logic h,
      input logic [3:0] et, input logic [3:0] es);
      cyc(a, w, h);
      chk("target", 32'(et), 32'(target));
      chk("strobes", 32'(es), 32'({rom_n, rd_n, wr_n, steer}));
   endtask
   task automatic cc(input logic [2:0] e);
      chk("cache", 32'(e), 32'({l1_cacheable, l2_cacheable, wb_sel}));
   endtask
   task automatic t_regs();
      logic [7:0] m [4] = '{8'hFF, 8'hFF, 8'h6F, 8'h03};
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 12; i++) rd(8'h30 + 8'(i), 32'h0);
      for (int i = 0; i < 8; i++) wr(8'h30 + 8'(i), 8'hA5 ^ 8'(i));
      for (int i = 0; i < 8; i++) begin
         rd(8'h30 + 8'(i), 32'((8'hA5 ^ 8'(i)) & m[i % 4]));
         wr(8'h30 + 8'(i), 8'h00);
      end
      apb(1'b1, 8'h3F, 8'h55, r, e);
      chk("pslverr", 32'h1, 32'(e));
      rd(8'h3F, 32'h0);
      $display("t_regs done");
   endtask
   task automatic t_rom();
      dec(32'hFFF00000, 1'b0, 1'b0, TR, 4'h3);
      dec(32'h8FF12344, 1'b0, 1'b0, TR, 4'h3);
      dec(32'hFFFFFFF0, 1'b1, 1'b0, TR, 4'h4);
      dec(32'h72345678, 1'b0, 1'b1, TD, 4'hE);
      chk("dram_addr", 32'h02345678, 32'(dram_addr));
      dec(32'h92345678, 1'b1, 1'b1, TI, 4'hC);
      chk("isa_addr", 32'h00345678, 32'(isa_addr));
      $display("t_rom done");
   endtask
   task automatic t_shadow();
      dec(32'h000E8000, 1'b0, 1'b0, TI, 4'hA);
      wr(8'h40, 8'h20);
      dec(32'h000E4000, 1'b0, 1'b0, TD, 4'hE);
      dec(32'h000E4000, 1'b1, 1'b0, TI, 4'hC);
      wr(8'h41, 8'h20);
      wr(8'h42, 8'h20);
      wr(8'h40, 8'h00);
      wr(8'h41, 8'h00);
      dec(32'h000E8000, 1'b0, 1'b0, TD, 4'hE);
      dec(32'h000E8000, 1'b1, 1'b0, TD, 4'hE);
      dec(32'h000E0000, 1'b0, 1'b0, TI, 4'hA);
      wr(8'h42, 8'h01);
      dec(32'h000A1000, 1'b0, 1'b0, TD, 4'hE);
      dec(32'h000A1000, 1'b1, 1'b0, TD, 4'hE);
      dec(32'h000B1000, 1'b1, 1'b0, TI, 4'hC);
      wr(8'h42, 8'h00);
      $display("t_shadow done");
   endtask
   task automatic t_window();
      logic [2:0] ca [4] = '{3'h7, 3'h0, 3'h6, 3'h7};
      wr(8'h43, 8'h03);
      wr(8'h30, 8'h10);
      wr(8'h32, 8'h04);
      dec(32'h001F0000, 1'b0, 1'b1, TD, 4'hE);
      chk("win_cs", 32'h1, 32'(win_cs));
      dec(32'h00200000, 1'b0, 1'b1, TD, 4'hE);
      chk("win_cs", 32'h0, 32'(win_cs));
      for (int c = 0; c < 4; c++) begin
         wr(8'h33, 8'(c));
         dec(32'h00180000, 1'b0, 1'b1, TD, 4'hE);
         cc(ca[c]);
      end
      // sweep cacheable dram before the hole goes in
      for (int i = 0; i < 4; i++) begin
         dec(32'h00400000 + 32'(i * 16), 1'b0, 1'b1, TD, 4'hE);
      end
      wr(8'h32, 8'h24);
      dec(32'h00180000, 1'b0, 1'b1, TI, 4'hA);
      cc(3'h5);
      wr(8'h33, 8'h02);
      dec(32'h00180000, 1'b1, 1'b1, TI, 4'hC);
      cc(3'h4);
      wr(8'h32, 8'h64);
      dec(32'h00180000, 1'b0, 1'b1, TL, 4'hE);
      wr(8'h32, 8'h44);
      dec(32'h00180000, 1'b0, 1'b1, TD, 4'hE);
      wr(8'h32, 8'h04);
      wr(8'h33, 8'h03);
      wr(8'h34, 8'h10);
      wr(8'h37, 8'h01);
      wr(8'h36, 8'h24);
      dec(32'h00180000, 1'b0, 1'b1, TI, 4'hA);
      cc(3'h5);
      wr(8'h34, 8'h00);
      wr(8'h35, 8'h08);
      wr(8'h36, 8'h2B);
      dec(32'h1FFF0000, 1'b0, 1'b1, TI, 4'hA);
      chk("win_cs", 32'h2, 32'(win_cs));
      dec(32'h07FF0000, 1'b0, 1'b1, TD, 4'hE);
      $display("t_window done");
   endtask
   task automatic t_ldev();
      @(posedge pclk);
      lcl_en <= 1'b1;
      cyc_addr <= 32'hFFF00000;
      repeat (6) @(posedge pclk);
      cyc(32'hFFF00000, 1'b0, 1'b0);
      chk("target", 32'(TL), 32'(target));
      chk("isa", 32'h6, 32'({rd_n, wr_n, steer}));
      cyc(32'hFFF00000, 1'b1, 1'b0);
      chk("isa", 32'h6, 32'({rd_n, wr_n, steer}));
      @(posedge pclk);
      lcl_en <= 1'b0;
      repeat (6) @(posedge pclk);
      dec(32'hFFF00000, 1'b0, 1'b0, TR, 4'h3);
      $display("t_ldev done");
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_rom();
      t_shadow();
      t_window();
      t_ldev();
      test_done();
   end
endmodule
`default_nettype wire

/* verification/msd_decoder_sva.sv */
// concurrent assertions on the memory space decoder ports
`timescale 1ns/1ps
`default_nettype none
module msd_decoder_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // memory cycle request
   input wire logic cyc_valid,
   input wire logic cyc_write,
   input wire logic [31:0] cyc_addr,
   // cycle results
   input wire logic decode_valid,
   input wire logic [3:0] target,
   input wire logic boot_rom_select_n,
   input wire logic isa_mem_read_n,
   input wire logic isa_mem_write_n,
   input wire logic peripheral_data_bus_steer,
   input wire logic [23:0] isa_addr,
   input wire logic [27:0] dram_addr,
   input wire logic l2_cacheable
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [31:0] addr_q;
   logic top;
   // the decoder ignores bits 30:28, so the top decode skips them too
   assign top = cyc_addr[31] && cyc_addr[27:20] == 8'hFF;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= 32'h0;
      end else begin
         addr_q <= cyc_addr;
      end
   end
   property p_rom_rd;
      cyc_valid && !cyc_write && top |=> target == msd_pkg::TGT_LOCAL ||
         (!boot_rom_select_n && !isa_mem_read_n && peripheral_data_bus_steer);
   endproperty
   a_rom_rd: assert property (p_rom_rd) else $error("top read");
   property p_rom_wr;
      cyc_valid && cyc_write && top |=> target == msd_pkg::TGT_LOCAL ||
         (!boot_rom_select_n && !isa_mem_write_n);
   endproperty
   a_rom_wr: assert property (p_rom_wr) else $error("top write");
   property p_isa_addr;
      cyc_valid |=> decode_valid && isa_addr == addr_q[23:0];
   endproperty
   a_isa_addr: assert property (p_isa_addr) else $error("isa addr");
   property p_dram_addr;
      cyc_valid |=> dram_addr == addr_q[27:0];
   endproperty
   a_dram_addr: assert property (p_dram_addr) else $error("dram");
   property p_upper;
      cyc_valid && cyc_addr[31] |=> target != msd_pkg::TGT_DRAM;
   endproperty
   a_upper: assert property (p_upper) else $error("upper half");
   property p_local_quiet;
      decode_valid && target == msd_pkg::TGT_LOCAL |->
         isa_mem_read_n && isa_mem_write_n;
   endproperty
   a_local_quiet: assert property (p_local_quiet) else $error("ldev");
   property p_l2_dram;
      l2_cacheable |-> target == msd_pkg::TGT_DRAM;
   endproperty
   a_l2_dram: assert property (p_l2_dram) else $error("l2 target");
   property p_steer;
      peripheral_data_bus_steer |-> decode_valid && !boot_rom_select_n &&
         addr_q[31] && addr_q[27:20] == 8'hFF;
   endproperty
   a_steer: assert property (p_steer) else $error("steer");
   property p_idle;
      !cyc_valid |=> !decode_valid && boot_rom_select_n &&
         isa_mem_read_n && isa_mem_write_n;
   endproperty
   a_idle: assert property (p_idle) else $error("idle strobes");
endmodule
bind msd_decoder msd_decoder_sva i_sva (.pclk(pclk), .presetn(presetn),
   .cyc_valid(cyc_valid), .cyc_write(cyc_write), .cyc_addr(cyc_addr),
   .decode_valid(decode_valid), .target(target),
   .boot_rom_select_n(boot_rom_select_n), .isa_mem_read_n(isa_mem_read_n),
   .isa_mem_write_n(isa_mem_write_n),
   .peripheral_data_bus_steer(peripheral_data_bus_steer),
   .isa_addr(isa_addr), .dram_addr(dram_addr), .l2_cacheable(l2_cacheable));
`default_nettype wire

/* verification/msd_local_slave.sv */
// local-bus memory slave model that claims its own address block
`timescale 1ns/1ps
`default_nettype none
module msd_local_slave #(
   parameter logic [7:0] CLAIM_BASE = 8'hFF
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench control and cycle address
   input wire logic claim_en,
   input wire logic [31:0] cyc_addr,
   // claim pin, pulled up when released
   output logic local_dev_claim_n
);
   logic hit;
   // decodes bits 31:24 only, 30:28 included: the slave does not follow the 256MB repeat
   assign hit = claim_en && cyc_addr[31:24] == CLAIM_BASE;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         local_dev_claim_n <= 1'b1;
      end else begin
         local_dev_claim_n <= !hit;
      end
   end
endmodule
`default_nettype wire
